// ==== rtl/dpes_regs.vh ====
`ifndef DPES_REGS_VH
`define DPES_REGS_VH
// ==========================================================
// Overview of operation
// - holdover flag, bit 2, sets on entry to holdover and holds until a one is written.
// - loss-of-lock flag, bit 0, sets on each locked-to-unlocked edge, held until written one.
// - counter-limit flag, bit 1, is set while the unlock counter is above the threshold.
// - writing one to the counter-limit flag does nothing while the count is above threshold.
// - counter-limit flag reads one if the count passed the threshold since its last clear.
// - a 4-bit unlock counter in bits 3:0 counts up by one on every deassertion of lock while below its maximum, except in a cycle with an accepted count write.
// - the unlock counter stops at its maximum and never wraps.
// - a software write loads the unlock counter: zero clears it, other values preset it.
// - unlock counter writes are ignored while the loop is clock gated or in soft reset.
// - the integrator readback shows a 29-bit value in bits 28:0, upper bits zero.
// - the phase readback shows a two's complement value in bits 29:0, bits 31:30 zero.
// - one phase step equals the converter oscillator period divided by 496.
// - state-change flag, bit 3, sets on any state transition, held until written one.
// - lock status is one bit, one meaning locked, and its falling edges drive flag and counter.

// ==========================================================
// register offsets
`define DPES_EVENT_OFS      12'h000
`define DPES_UNLOCK_CNT_OFS 12'h004
`define DPES_INTEG_OFS      12'h008
`define DPES_PHASE_OFS      12'h00C

// ==========================================================
// fields
`define DPES_LOL_BIT        0
`define DPES_LIMIT_BIT      1
`define DPES_HOLD_BIT       2
`define DPES_STCH_BIT       3
`define DPES_CNT_W          4
`define DPES_INTEG_W        29
`define DPES_PHASE_W        30
`define DPES_PHASE_DIV      496
`define DPES_HOLDOVER_CODE  3'h2
`define DPES_CNT_MAX        4'hF
`define DPES_RST_VAL        32'h0000_0000
`endif

// ==== rtl/dpes_sync3.v ====
`timescale 1ns/1ps
`include "dpes_regs.vh"
// three-stage synchroniser; a change counts once stages two and three agree
module dpes_sync3 #(
	parameter W = 1
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			q    <= {W{1'b0}};
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				q <= s3_r;
			end
		end
	end
endmodule

// ==== rtl/dpes_apb_slave.v ====
`timescale 1ns/1ps
`include "dpes_regs.vh"
// zero-wait apb decode; write strobes on the access phase, read strobe on the setup phase
module dpes_apb_slave (
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	output wire        wr_evt,
	output wire        wr_cnt,
	output wire        rd_go,
	output wire        unmapped
);
	wire acc;

	assign acc      = psel & penable;
	assign wr_evt   = acc & pwrite & (paddr == `DPES_EVENT_OFS);
	assign wr_cnt   = acc & pwrite & (paddr == `DPES_UNLOCK_CNT_OFS);
	assign rd_go    = psel & ~penable & ~pwrite;
	assign unmapped = (paddr != `DPES_EVENT_OFS) && (paddr != `DPES_UNLOCK_CNT_OFS)
		&& (paddr != `DPES_INTEG_OFS) && (paddr != `DPES_PHASE_OFS);
endmodule

// ==== rtl/dpes_event_regs.v ====
`timescale 1ns/1ps
`include "dpes_regs.vh"
module dpes_event_regs (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        lock_status,
	input  wire [2:0]  loop_state,
	input  wire        loop_clock_gate,
	input  wire        loop_soft_reset,
	input  wire [3:0]  unlock_threshold,
	input  wire [28:0] integrator_value,
	input  wire [29:0] phase_value,
	output reg  [3:0]  event_flags,
	output reg  [3:0]  unlock_count
);
	// ==========================================================
	// synchronised inputs
	wire        lock_s;
	wire [2:0]  state_s;
	wire        gate_s;
	wire        srst_s;
	wire [3:0]  thr_s;

	dpes_sync3 #(.W(1)) u_lock (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (lock_status),
		.q       (lock_s)
	);
	dpes_sync3 #(.W(3)) u_state (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (loop_state),
		.q       (state_s)
	);
	dpes_sync3 #(.W(2)) u_ctl (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({loop_clock_gate, loop_soft_reset}),
		.q       ({gate_s, srst_s})
	);
	// threshold is quasi-static configuration; a mixed snapshot costs one cycle at most
	dpes_sync3 #(.W(4)) u_thr (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (unlock_threshold),
		.q       (thr_s)
	);

	// ==========================================================
	// bus decode
	wire wr_evt;
	wire wr_cnt;
	wire rd_go;
	wire unmapped;

	dpes_apb_slave u_apb (
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.wr_evt   (wr_evt),
		.wr_cnt   (wr_cnt),
		.rd_go    (rd_go),
		.unmapped (unmapped)
	);

	// ==========================================================
	// event detection
	reg        lock_d_r;
	reg [2:0]  state_d_r;
	reg        prime_r;
	wire       lol_evt;
	wire       st_evt;
	wire       hold_evt;
	wire       over;
	wire [3:0] w1c;

	// first cycle after reset only loads history, so no false edges
	assign lol_evt  = prime_r & lock_d_r & ~lock_s;
	assign st_evt   = prime_r & (state_s != state_d_r);
	assign hold_evt = st_evt & (state_s == `DPES_HOLDOVER_CODE);
	assign over     = unlock_count > thr_s;
	assign w1c      = wr_evt ? pwdata[3:0] : 4'h0;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_d_r  <= 1'b0;
			state_d_r <= 3'h0;
			prime_r   <= 1'b0;
		end else begin
			lock_d_r  <= lock_s;
			state_d_r <= state_s;
			prime_r   <= 1'b1;
		end
	end

	// ==========================================================
	// sticky flags: set wins over clear
	reg [3:0] flags_nxt;

	always @* begin
		flags_nxt = event_flags & ~w1c;
		if (lol_evt) begin
			flags_nxt[`DPES_LOL_BIT] = 1'b1;
		end
		// limit flag holds while condition persists, sticky after
		if (over) begin
			flags_nxt[`DPES_LIMIT_BIT] = 1'b1;
		end
		if (hold_evt) begin
			flags_nxt[`DPES_HOLD_BIT] = 1'b1;
		end
		if (st_evt) begin
			flags_nxt[`DPES_STCH_BIT] = 1'b1;
		end
	end

	// ==========================================================
	// unlock counter
	reg [3:0] cnt_nxt;
	wire      cnt_wr_ok;

	assign cnt_wr_ok = wr_cnt & ~gate_s & ~srst_s;

	always @* begin
		cnt_nxt = unlock_count;
		if (cnt_wr_ok) begin
			cnt_nxt = pwdata[3:0];
		end else if (lol_evt && unlock_count != `DPES_CNT_MAX) begin
			cnt_nxt = unlock_count + 4'h1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_flags  <= 4'h0;
			unlock_count <= 4'h0;
		end else begin
			event_flags  <= flags_nxt;
			unlock_count <= cnt_nxt;
		end
	end

	// ==========================================================
	// read path: data registered in setup, ready in access phase
	reg [31:0] rd_nxt;

	always @* begin
		case (paddr)
			`DPES_EVENT_OFS:      rd_nxt = {28'h0, event_flags};
			`DPES_UNLOCK_CNT_OFS: rd_nxt = {28'h0, unlock_count};
			// unit is oscillator period / DPES_PHASE_DIV
			`DPES_INTEG_OFS:      rd_nxt = {3'h0, integrator_value};
			`DPES_PHASE_OFS:      rd_nxt = {2'h0, phase_value};
			default:              rd_nxt = `DPES_RST_VAL;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `DPES_RST_VAL;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & unmapped;
			if (rd_go) begin
				prdata <= rd_nxt;
			end
		end
	end
endmodule

// ==== verification/dpes_event_regs_chk.sv ====
`timescale 1ns/1ps
// ==========================================
// event register checker
module dpes_event_regs_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        lock_status,
	input wire        loop_clock_gate,
	input wire        loop_soft_reset,
	input wire [3:0]  unlock_threshold,
	input wire [3:0]  event_flags,
	input wire [3:0]  unlock_count
);
	wire       ev_wr = psel && penable && pwrite && (paddr == 12'h000);
	wire       cn_wr = psel && penable && pwrite && (paddr == 12'h004);
	wire [3:0] wr_val = pwdata[3:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// six cycles outlast the three-flop synchroniser
	sequence s_open; (!loop_clock_gate && !loop_soft_reset)[*6] ##0 cn_wr; endsequence
	sequence s_shut; loop_clock_gate[*6] ##0 cn_wr; endsequence
	sequence s_halt; loop_soft_reset[*6] ##0 cn_wr; endsequence
	sequence s_drop; lock_status[*6] ##1 (!lock_status && !ev_wr)[*6]; endsequence
	property p_hold(int b);
		event_flags[b] && !(ev_wr && pwdata[b]) |=> event_flags[b];
	endproperty
	chk_lol_hold: assert property (p_hold(0)) else $error("unlock flag lost");
	chk_limit_hold: assert property (p_hold(1)) else $error("limit flag lost");
	chk_hold_keep: assert property (p_hold(2)) else $error("holdover flag lost");
	chk_state_keep: assert property (p_hold(3)) else $error("state flag lost");
	chk_lol_set: assert property (s_drop |-> event_flags[0])
		else $error("unlock flag unset");
	chk_limit_set: assert property ((unlock_count > unlock_threshold)[*3]
		|-> event_flags[1]) else $error("limit flag unset");
	chk_count_sat: assert property (unlock_count == 4'hF && !cn_wr
		|=> unlock_count == 4'hF) else $error("counter wrapped");
	chk_count_load: assert property (s_open |=> unlock_count == $past(wr_val))
		else $error("counter not loaded");
	chk_count_shut: assert property (s_shut |=> unlock_count == $past(unlock_count)
		|| unlock_count == $past(unlock_count) + 4'h1) else $error("gated write loaded");
	chk_count_halt: assert property (s_halt |=> unlock_count == $past(unlock_count)
		|| unlock_count == $past(unlock_count) + 4'h1) else $error("reset write loaded");
endmodule
bind dpes_event_regs dpes_event_regs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.lock_status(lock_status), .loop_clock_gate(loop_clock_gate),
	.loop_soft_reset(loop_soft_reset), .unlock_threshold(unlock_threshold),
	.event_flags(event_flags), .unlock_count(unlock_count));

// ==== verification/tb_dpll_event_status_regs.sv ====
`timescale 1ns/1ps
// ==========================================
// bench
module tb_dpll_event_status_regs;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic        lock_status = 0, loop_clock_gate = 0, loop_soft_reset = 0, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0]  loop_state = 0;
	logic [3:0]  unlock_threshold = 0, event_flags, unlock_count, m_flg = 0;
	logic [28:0] integrator_value = 0;
	logic [29:0] phase_value = 0;
	int          n_errors = 0, checks = 0, cyc = 0, m_cnt = 0, m_thr, i;
	int          st[6] = '{4, 1, 2, 0, 5, 2};
	dpes_event_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .lock_status, .loop_state, .loop_clock_gate, .loop_soft_reset,
		.unlock_threshold, .integrator_value, .phase_value, .event_flags, .unlock_count);
	initial begin
		forever #20 pclk = ~pclk;
	end
	// ==========================================
	// tasks
	task conclude;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: exp %h got %h", $time, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the bench timeout ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(e, rd);
	endtask
	// set wins, so the limit flag reappears while the count stays high
	function void lim;
		if (m_cnt > m_thr) m_flg[1] = 1'b1;
	endfunction
	task wevt(input logic [3:0] d);
		apb(1'b1, 12'h000, {28'h0, d});
		m_flg = m_flg & ~d;
		lim();
	endtask
	task wcnt(input logic [3:0] d);
		apb(1'b1, 12'h004, {28'h0, d});
		if (!loop_clock_gate && !loop_soft_reset) m_cnt = d;
		lim();
	endtask
	task vchk;
		rchk(12'h000, {28'h0, m_flg});
		rchk(12'h004, m_cnt);
	endtask
	// pins pass a synchroniser, so each level is held eight cycles
	task drop;
		lock_status <= 1'b1;
		repeat (8) @(posedge pclk);
		lock_status <= 1'b0;
		repeat (8) @(posedge pclk);
		m_cnt = (m_cnt < 15) ? m_cnt + 1 : 15;
		m_flg[0] = 1'b1;
		lim();
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			conclude();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(29797));
		m_thr = $urandom % 15;
		unlock_threshold <= m_thr[3:0];
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++) rchk(12'(i * 4), 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		cmp(32'h1, {31'h0, er});
		for (i = 0; i < 18; i++) begin
			drop();
			vchk();
		end
		wevt(4'hF);
		vchk();
		wcnt(4'h0);
		wevt(4'h2);
		vchk();
		wcnt(4'($urandom % 16));
		vchk();
		for (i = 0; i < 2; i++) begin
			{loop_soft_reset, loop_clock_gate} <= 2'(i + 1);
			repeat (8) @(posedge pclk);
			wcnt(4'(m_cnt + 5));
			vchk();
			{loop_soft_reset, loop_clock_gate} <= 2'b00;
			repeat (8) @(posedge pclk);
		end
		for (i = 0; i < 6; i++) begin
			loop_state <= st[i][2:0];
			repeat (8) @(posedge pclk);
			m_flg[3] = 1'b1;
			if (st[i] == 2) m_flg[2] = 1'b1;
			vchk();
			wevt(4'hD);
		end
		integrator_value <= 29'($urandom);
		phase_value <= 30'($urandom);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		rchk(12'h008, {3'h0, integrator_value});
		rchk(12'h00C, {2'h0, phase_value});
		conclude();
	end
endmodule
